// ===== src/dee_array.sv
// Purpose: Storage array for the data EEPROM words.
// Assumes: One write port and one read port per clock.
// Notes: Erased words read as all ones.
`timescale 1ns/1ps
module dee_array #(
  parameter int WORDS = 4096,
  parameter int AW = 12
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [15:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [15:0] rdata
);
  // ============================================================
  // Memory
  logic [15:0] mem [WORDS];

  // No reset: nonvolatile contents survive every reset.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// ===== src/dee_ctrl.sv
// Purpose: Data EEPROM access controller with an AXI4-Lite register slave.
// Assumes: por_rst is power-on; rst covers master clear and watchdog too.
// Notes: Table accesses are issued as register commands by the core.
`timescale 1ns/1ps
`include "dee_defs.svh"
module dee_ctrl #(
  parameter int WRITE_CYCLES = `DEE_WRITE_CYCLES,
  parameter int WORDS = 4096,
  parameter int AW = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic por_rst,
  input wire logic warm_reset_seen,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic busy
);
  localparam int CW = $clog2(WRITE_CYCLES + 1);

  // ============================================================
  // State
  typedef struct packed {
    dee_pkg::dee_state_t st;
    logic wr;
    logic [3:0] op;
    logic [7:0] addr_upper;
    logic key_armed;
    logic unlocked;
    logic done_flag;
    logic [7:0] page;
    logic [15:0] ptr;
    logic [15:0] tdata;
    logic [CW-1:0] cnt;
    logic [3:0] idx;
    logic aw_got;
    logic w_got;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic rd_pend;
    logic [2:0] rd_kind;
  } dee_state_s_t;

  dee_state_s_t s_reg;
  dee_state_s_t s_next;
  logic write_enable_bit_reg;
  logic write_error_flag_reg;
  logic [15:0] latch_mem [`DEE_BLOCK_WORDS];
  logic latch_we;
  logic [3:0] latch_idx;
  logic [15:0] arr_rdata;
  logic arr_we;
  logic [AW-1:0] arr_waddr;
  logic [15:0] arr_wdata;
  logic [AW-1:0] arr_raddr;
  logic in_window;
  logic [15:0] wr_addr;
  logic [3:0] base_idx;
  logic [15:0] addr_keep_reg;
  logic [15:0] addr_low_next;
  logic op_live_reg;
  logic bus_commit;

  // Byte address of the program or erase target. The low half lives in
  // the power-on domain so that a warm reset leaves it for a retry.
  assign wr_addr = addr_keep_reg;
  assign in_window = (s_reg.addr_upper == `DEE_BASE_UPPER) &&
    (wr_addr[15:12] == 4'(`DEE_BASE_LOW >> 12));
  assign base_idx = wr_addr[4:1];
  // A write whose address and data are both held is applied this cycle unless the previous write's response is still pending.
  assign bus_commit = s_reg.aw_got && s_reg.w_got && !s_reg.bvalid;

  // Write enable clears only at power-up; error flag survives warm resets.
  // The state register is already cleared when the reset cause is seen, so
  // a copy of the busy state in this domain tells whether a write was cut.
  always_ff @(posedge clk or posedge por_rst) begin
    if (por_rst) begin
      write_enable_bit_reg <= 1'b0;
      write_error_flag_reg <= 1'b0;
      op_live_reg <= 1'b0;
    end else begin
      op_live_reg <= s_next.st != dee_pkg::DEE_IDLE;
      if (warm_reset_seen && rst && op_live_reg) begin
        write_error_flag_reg <= 1'b1;
      end else if (bus_commit && s_reg.aw_addr == `DEE_OFS_CONTROL &&
                   s_reg.w_strb[1]) begin
        write_enable_bit_reg <= s_reg.w_data[`DEE_CTL_WRITE_ENABLE_BIT];
        write_error_flag_reg <= s_reg.w_data[`DEE_CTL_WRITE_ERROR_FLAG];
      end
    end
  end

  // ============================================================
  // Write latches and the array
  always_ff @(posedge clk) begin
    if (latch_we) begin
      latch_mem[latch_idx] <= s_reg.tdata;
    end
  end

  // The array answers one cycle after the address, hence the pending flag.
  dee_array #(.WORDS(WORDS), .AW(AW)) u_array (
    .clk(clk),
    .we(arr_we),
    .waddr(arr_waddr),
    .wdata(arr_wdata),
    .raddr(arr_raddr),
    .rdata(arr_rdata)
  );

  // ============================================================
  // Next state
  always_comb begin
    logic wr_fire;
    logic [15:0] cdata;
    logic is_block;
    logic is_erase;
    s_next = s_reg;
    addr_low_next = addr_keep_reg;
    latch_we = 1'b0;
    latch_idx = s_reg.ptr[4:1];
    arr_we = 1'b0;
    arr_waddr = AW'(wr_addr[AW:1]);
    arr_wdata = 16'hffff;
    arr_raddr = AW'(s_reg.ptr[AW:1]);
    cdata = s_reg.w_data[15:0];
    is_block = s_reg.op[1];
    is_erase = s_reg.op[0];
    wr_fire = 1'b0;

    // AXI write channels are taken in either order.
    if (s_axi_awvalid && !s_reg.aw_got) begin
      s_next.aw_got = 1'b1;
      s_next.aw_addr = {s_axi_awaddr[11:2], 2'b00};
    end
    if (s_axi_wvalid && !s_reg.w_got) begin
      s_next.w_got = 1'b1;
      s_next.w_data = s_axi_wdata;
      s_next.w_strb = s_axi_wstrb;
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end

    if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = 2'b00;
      s_next.key_armed = 1'b0;
      case (s_reg.aw_addr)
        `DEE_OFS_CONTROL: begin
          // The running operation keeps its code until it ends.
          if (s_reg.st == dee_pkg::DEE_IDLE) begin
            s_next.op = cdata[`DEE_CTL_OP_HI:`DEE_CTL_OP_LO];
          end
          // Clears are ignored; set starts only when enabled and unlocked.
          // A word that clears write enable cannot start anything either.
          if (cdata[`DEE_CTL_WR] && !s_reg.wr && write_enable_bit_reg &&
              cdata[`DEE_CTL_WRITE_ENABLE_BIT] && s_reg.unlocked &&
              s_reg.st == dee_pkg::DEE_IDLE) begin
            wr_fire = 1'b1;
          end
          s_next.unlocked = 1'b0;
        end
        `DEE_OFS_ADDR_LOW: addr_low_next = cdata;
        `DEE_OFS_ADDR_UPPER: s_next.addr_upper = cdata[7:0];
        // Any other write between the two key words disarms the sequence.
        `DEE_OFS_UNLOCK_KEY: begin
          s_next.unlocked = 1'b0;
          if (cdata == `DEE_KEY_FIRST) begin
            s_next.key_armed = 1'b1;
          end else if (cdata == `DEE_KEY_SECOND && s_reg.key_armed) begin
            s_next.unlocked = 1'b1;
          end
        end
        `DEE_OFS_IRQ_FLAGS: begin
          if (!cdata[`DEE_IRQ_DONE_BIT]) begin
            s_next.done_flag = 1'b0;
          end
        end
        `DEE_OFS_TABLE_PAGE: s_next.page = cdata[7:0];
        `DEE_OFS_TABLE_PTR: s_next.ptr = cdata;
        `DEE_OFS_TABLE_DATA: s_next.tdata = cdata;
        `DEE_OFS_TABLE_CMD: begin
          if (cdata[`DEE_CMD_WRITE]) begin
            latch_we = 1'b1;
          end else begin
            s_next.rd_pend = 1'b1;
            s_next.rd_kind = cdata[2:0];
          end
        end
        default: s_next.bresp = 2'b10;
      endcase
    end

    // Table read completes one cycle after the array lookup.
    if (s_reg.rd_pend) begin
      s_next.rd_pend = 1'b0;
      if (s_reg.rd_kind[`DEE_CMD_BYTE]) begin
        s_next.tdata = s_reg.rd_kind[`DEE_CMD_BSEL] ?
          {8'h00, arr_rdata[15:8]} : {8'h00, arr_rdata[7:0]};
      end else begin
        s_next.tdata = arr_rdata;
      end
    end

    // AXI read: one cycle to answer, held until rready.
    // Table data taken while an operation runs may be a stale word.
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s_reg.rvalid) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = 2'b00;
      case ({s_axi_araddr[11:2], 2'b00})
        `DEE_OFS_CONTROL: s_next.rdata = {16'h0000, s_reg.wr, write_enable_bit_reg,
          write_error_flag_reg, s_reg.st != dee_pkg::DEE_IDLE, 8'h00, s_reg.op};
        `DEE_OFS_ADDR_LOW: s_next.rdata = {16'h0000, addr_keep_reg};
        `DEE_OFS_ADDR_UPPER: s_next.rdata = {24'h000000, s_reg.addr_upper};
        `DEE_OFS_UNLOCK_KEY: s_next.rdata = 32'h00000000;
        `DEE_OFS_IRQ_FLAGS: s_next.rdata = {31'h0, s_reg.done_flag};
        `DEE_OFS_TABLE_PAGE: s_next.rdata = {24'h000000, s_reg.page};
        `DEE_OFS_TABLE_PTR: s_next.rdata = {16'h0000, s_reg.ptr};
        `DEE_OFS_TABLE_DATA: s_next.rdata = {16'h0000, s_reg.tdata};
        `DEE_OFS_TABLE_CMD: s_next.rdata = 32'h00000000;
        default: begin
          s_next.rdata = 32'h00000000;
          s_next.rresp = 2'b10;
        end
      endcase
    end

    // ============================================================
    // Program and erase sequencer; runs beside the bus, never stalls it.
    case (s_reg.st)
      dee_pkg::DEE_IDLE: begin
        if (wr_fire && in_window) begin
          s_next.wr = 1'b1;
          s_next.cnt = '0;
          s_next.idx = '0;
          // The code written with the start decides erase or program.
          s_next.st = s_next.op[0] ? dee_pkg::DEE_ERASE :
            dee_pkg::DEE_PROGRAM;
        end
      end
      dee_pkg::DEE_ERASE, dee_pkg::DEE_PROGRAM: begin
        // Counter paces the operation near the typical write time.
        s_next.cnt = s_reg.cnt + CW'(1);
        if (s_reg.cnt == CW'(WRITE_CYCLES - 1)) begin
          s_next.st = dee_pkg::DEE_FINISH;
        end
      end
      dee_pkg::DEE_FINISH: begin
        // One word per cycle; a block spends sixteen cycles here.
        arr_we = 1'b1;
        latch_idx = is_block ? s_reg.idx : base_idx;
        arr_waddr = is_block ?
          AW'({wr_addr[AW:5], s_reg.idx}) : AW'(wr_addr[AW:1]);
        arr_wdata = is_erase ? 16'hffff : latch_mem[latch_idx];
        s_next.idx = s_reg.idx + 4'h1;
        if (!is_block || s_reg.idx == 4'(`DEE_BLOCK_WORDS - 1)) begin
          s_next.st = dee_pkg::DEE_IDLE;
          s_next.wr = 1'b0;
          s_next.done_flag = 1'b1;
        end
      end
      default: s_next.st = dee_pkg::DEE_IDLE;
    endcase
  end

  // The low address register is kept across warm resets.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '{st: dee_pkg::DEE_IDLE, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  // Power-on is the only reset that clears the low address.
  always_ff @(posedge clk or posedge por_rst) begin
    if (por_rst) begin
      addr_keep_reg <= 16'h0000;
    end else begin
      addr_keep_reg <= addr_low_next;
    end
  end

  // ============================================================
  // Outputs
  assign s_axi_awready = !s_reg.aw_got;
  assign s_axi_wready = !s_reg.w_got;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = !s_reg.rvalid;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rresp = s_reg.rresp;
  assign s_axi_rdata = s_reg.rdata;
  assign busy = s_reg.st != dee_pkg::DEE_IDLE;
endmodule

// ===== src/dee_defs.svh
// Purpose: Offsets, field positions, unlock keys, window, sizes and timing counts.
// Assumes: 40 MHz system clock, 32-bit AXI4-Lite register bus.
// Notes: Definitions only.
`ifndef DEE_DEFS_SVH
`define DEE_DEFS_SVH

// ============================================================
// Register byte offsets
`define DEE_OFS_CONTROL 12'h000
`define DEE_OFS_ADDR_LOW 12'h004
`define DEE_OFS_ADDR_UPPER 12'h008
`define DEE_OFS_UNLOCK_KEY 12'h00c
`define DEE_OFS_IRQ_FLAGS 12'h010
`define DEE_OFS_TABLE_PAGE 12'h014
`define DEE_OFS_TABLE_PTR 12'h018
`define DEE_OFS_TABLE_DATA 12'h01c
`define DEE_OFS_TABLE_CMD 12'h020

// ============================================================
// Control and IRQ flag register fields
`define DEE_CTL_WR 15
`define DEE_CTL_WRITE_ENABLE_BIT 14
`define DEE_CTL_WRITE_ERROR_FLAG 13
`define DEE_CTL_BUSY 12
`define DEE_CTL_OP_HI 3
`define DEE_CTL_OP_LO 0
`define DEE_OP_WORD_WRITE 4'h4
`define DEE_OP_WORD_ERASE 4'h5
`define DEE_OP_BLOCK_WRITE 4'h6
`define DEE_OP_BLOCK_ERASE 4'h7
`define DEE_IRQ_DONE_BIT 0

// Table command register fields.
`define DEE_CMD_WRITE 0
`define DEE_CMD_BYTE 1
`define DEE_CMD_BSEL 2

// ============================================================
// Unlock sequence, window and sizes
`define DEE_KEY_FIRST 16'h0055
`define DEE_KEY_SECOND 16'h00aa
`define DEE_BASE_UPPER 8'h7f
`define DEE_BASE_LOW 16'hf000
`define DEE_BLOCK_WORDS 16

// ============================================================
// Timing
`define DEE_CLK_HZ 40000000
`define DEE_WRITE_TIME_US 2000
`define DEE_WRITE_CYCLES ((`DEE_WRITE_TIME_US * (`DEE_CLK_HZ / 1000000)))

`endif

// ===== src/dee_pkg.sv
// Purpose: Types shared by the data EEPROM controller.
// Assumes: Nothing beyond the defines header.
// Notes: Types only.
package dee_pkg;
  typedef enum logic [1:0] {
    DEE_IDLE,
    DEE_ERASE,
    DEE_PROGRAM,
    DEE_FINISH
  } dee_state_t;
endpackage

// ===== testbench/dee_core.sv
// Purpose: Core side model issuing register cycles on the bus.
// Assumes: One write and one read at most in flight.
// Notes: Tasks are called by the bench.
`timescale 1ns/1ps
`include "dee_defs.svh"
module dee_core (
  input wire logic clk,
  input wire logic busy,
  output logic [11:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [11:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // ====================
  // Bus cycles
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    s_axi_wstrb = 4'hf;
  end
  task automatic wr(input logic [11:0] a, input logic [15:0] d,
    output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      aw_ok = aw_ok || s_axi_awready;
      w_ok = w_ok || s_axi_wready;
      s_axi_awvalid <= !aw_ok;
      s_axi_wvalid <= !w_ok;
    end
    do @(posedge clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [15:0] d,
    output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    d = s_axi_rdata[15:0];
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Enable and code go in first, since the start sees the enable already
  // held; a start is refused unless both key words come in a row and no control or key write falls between them and it.
  task automatic start(input logic [3:0] op, input logic write_enable_bit);
    logic [1:0] r;
    while (busy) @(posedge clk);
    wr(`DEE_OFS_CONTROL, {1'b0, write_enable_bit, 10'h000, op}, r);
    wr(`DEE_OFS_UNLOCK_KEY, `DEE_KEY_FIRST, r);
    wr(`DEE_OFS_UNLOCK_KEY, `DEE_KEY_SECOND, r);
    wr(`DEE_OFS_CONTROL, {1'b1, write_enable_bit, 10'h000, op}, r);
  endtask
endmodule

// ===== testbench/dee_ctrl_sva.sv
// Purpose: Port-level checks of the data EEPROM controller.
// Assumes: One clock domain, reset active high.
// Notes: Attached by bind at the foot of this file.
`timescale 1ns/1ps
`include "dee_defs.svh"
module dee_ctrl_sva #(
  parameter int WRITE_CYCLES = `DEE_WRITE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic busy
);
  // ====================
  // Helper logic
  // Operations are too long for repetition, so a counter measures them.
  logic [31:0] busy_cnt_reg;
  logic wr_take;
  assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_cnt_reg <= 32'h0;
    end else begin
      busy_cnt_reg <= busy ? busy_cnt_reg + 32'h1 : 32'h0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_op_length: assert property ($fell(busy) |->
    busy_cnt_reg >= WRITE_CYCLES - 1 && busy_cnt_reg <= 2 * WRITE_CYCLES + 8)
    else $error("operation length out of range");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_write_answer: assert property (wr_take |=> ##1 s_axi_bvalid)
    else $error("write not answered two cycles after take");
  a_one_read: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answered twice");
  a_unmapped_rd: assert property (s_axi_arvalid && s_axi_arready
    && {s_axi_araddr[11:2], 2'b00} > `DEE_OFS_TABLE_CMD
    |=> s_axi_rresp == 2'b10)
    else $error("unmapped read not refused");
  a_unmapped_wr: assert property (wr_take
    && {s_axi_awaddr[11:2], 2'b00} > `DEE_OFS_TABLE_CMD
    |=> ##1 s_axi_bresp == 2'b10)
    else $error("unmapped write not refused");
  a_no_write_enable_bit_start: assert property (wr_take && !busy
    && s_axi_awaddr == `DEE_OFS_CONTROL && !s_axi_wdata[`DEE_CTL_WRITE_ENABLE_BIT]
    |=> !busy [*3])
    else $error("operation started without write enable");
  a_rdata_upper: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
endmodule
bind dee_ctrl dee_ctrl_sva #(.WRITE_CYCLES(WRITE_CYCLES)) dee_ctrl_sva_inst (
  .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .busy);

// ===== testbench/tb_dee_ctrl.sv
// Purpose: Self-checking bench for the data EEPROM controller.
// Assumes: Shortened write time, core model on the register bus.
// Notes: Scenarios run in order and share the bus tasks.
`timescale 1ns/1ps
`include "dee_defs.svh"
module tb_dee_ctrl;
  localparam int WC = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic por_rst = 1'b1;
  logic warm_reset_seen = 1'b0;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, busy;
  logic [15:0] v;
  int n_mismatch = 0;
  int checked = 0;
  always #12.5 clk = ~clk;
  dee_ctrl #(.WRITE_CYCLES(WC)) dee_ctrl_inst (.clk, .rst, .por_rst,
    .warm_reset_seen, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .busy);
  dee_core dee_core_inst (.clk, .busy, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic w(input logic [11:0] a, input logic [15:0] d);
    dee_core_inst.wr(a, d, r);
  endtask
  task automatic rd(input logic [11:0] a);
    dee_core_inst.rd(a, v, r);
  endtask
  task automatic latch(input logic [15:0] a, input logic [15:0] d);
    w(`DEE_OFS_TABLE_PTR, a);
    w(`DEE_OFS_TABLE_DATA, d);
    w(`DEE_OFS_TABLE_CMD, 16'h0001);
  endtask
  // The result lands one cycle after the command is answered.
  task automatic tread(input logic [15:0] a, input logic [15:0] cmd);
    w(`DEE_OFS_TABLE_PTR, a);
    w(`DEE_OFS_TABLE_CMD, cmd);
    repeat (2) @(posedge clk);
    rd(`DEE_OFS_TABLE_DATA);
  endtask
  task automatic finish_op();
    @(negedge clk);
    repeat (4 * WC) if (busy) @(negedge clk);
    check({15'h0, busy}, 16'h0000);
    rd(`DEE_OFS_IRQ_FLAGS);
    check(v, 16'h0001);
    w(`DEE_OFS_IRQ_FLAGS, 16'h0000);
    rd(`DEE_OFS_IRQ_FLAGS);
    check(v, 16'h0000);
  endtask
  task automatic sc_por();
    rd(`DEE_OFS_CONTROL);
    check(v, 16'h0000);
    rd(12'h040);
    check({14'h0, r}, 16'h0002);
    w(12'h044, 16'h1234);
    check({14'h0, r}, 16'h0002);
  endtask
  task automatic sc_word();
    w(`DEE_OFS_TABLE_PAGE, 16'h007f);
    w(`DEE_OFS_ADDR_UPPER, 16'h007f);
    w(`DEE_OFS_ADDR_LOW, 16'hf002);
    dee_core_inst.start(`DEE_OP_WORD_ERASE, 1'b1);
    rd(`DEE_OFS_CONTROL);
    check(v, 16'hd005);
    w(`DEE_OFS_CONTROL, 16'h4005);
    rd(`DEE_OFS_CONTROL);
    check(v, 16'hd005);
    finish_op();
    rd(`DEE_OFS_CONTROL);
    check(v, 16'h4005);
    tread(16'hf002, 16'h0000);
    check(v, 16'hffff);
    latch(16'hf002, 16'ha5c3);
    dee_core_inst.start(`DEE_OP_WORD_WRITE, 1'b1);
    finish_op();
    tread(16'hf002, 16'h0000);
    check(v, 16'ha5c3);
    tread(16'hf002, 16'h0002);
    check({8'h00, v[7:0]}, 16'h00c3);
    tread(16'hf002, 16'h0006);
    check({8'h00, v[7:0]}, 16'h00a5);
  endtask
  task automatic sc_block();
    w(`DEE_OFS_ADDR_LOW, 16'hf040);
    dee_core_inst.start(`DEE_OP_BLOCK_ERASE, 1'b1);
    finish_op();
    for (int i = 0; i < `DEE_BLOCK_WORDS; i++) begin
      latch(16'hf040 + 16'(2 * i), 16'h1000 + 16'(i));
    end
    dee_core_inst.start(`DEE_OP_BLOCK_WRITE, 1'b1);
    finish_op();
    for (int i = 0; i < `DEE_BLOCK_WORDS; i++) begin
      tread(16'hf040 + 16'(2 * i), 16'h0000);
      check(v, 16'h1000 + 16'(i));
    end
  endtask
  task automatic sc_nowren();
    w(`DEE_OFS_ADDR_LOW, 16'hf002);
    latch(16'hf002, 16'h0f0f);
    dee_core_inst.start(`DEE_OP_WORD_WRITE, 1'b0);
    @(negedge clk);
    check({15'h0, busy}, 16'h0000);
    tread(16'hf002, 16'h0000);
    check(v, 16'ha5c3);
  endtask
  task automatic sc_abort();
    w(`DEE_OFS_ADDR_LOW, 16'hf004);
    dee_core_inst.start(`DEE_OP_WORD_ERASE, 1'b1);
    repeat (4) @(posedge clk);
    rst <= 1'b1;
    warm_reset_seen <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    warm_reset_seen <= 1'b0;
    rd(`DEE_OFS_CONTROL);
    check(v & 16'h2000, 16'h2000);
    check(v & 16'h4000, 16'h4000);
    rd(`DEE_OFS_ADDR_LOW);
    check(v, 16'hf004);
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    por_rst <= 1'b0;
    sc_por();
    sc_word();
    sc_block();
    sc_nowren();
    sc_abort();
    summarize();
  end
  initial begin
    repeat (8000) @(posedge clk);
    n_mismatch++;
    summarize();
  end
endmodule
